/* fwsfc_pkg.sv */
// Constants and carrier types for the flash write / security fuse block.
// Assumes the core presents one byte access per cycle on its SFR and XDATA buses.
package fwsfc_pkg;

   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] FLASH_CONTROL_ADDR = 8'hb2;
   localparam logic [15:0] XSFR_BASE = 16'hfc00;
   localparam logic [15:0] FUSE_BURN_PULSE_ADDR = 16'hffd1;
   localparam logic [15:0] FUSE_SETUP_KEY_ADDR = 16'hffd2;
   localparam logic [15:0] SECURITY_STATE_ADDR = 16'hffd7;

   // ----------------------------------------
   // Fields and keys
   // ----------------------------------------
   localparam int PWE_BIT = 0;
   localparam int MEEN_BIT = 1;
   localparam int SECURE_BIT = 6;
   localparam int FPE_BIT = 7;
   localparam int STRAP_BIT = 5;
   localparam int CP_FUSE_BIT = 0;
   localparam int DL_FUSE_BIT = 1;
   localparam logic [7:0] BURN_KEY = 8'ha6;
   localparam logic [7:0] SETUP_KEY = 8'h54;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Byte access from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } fwsfc_acc_s;

   // Request to the flash array
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
   } fwsfc_flash_s;

   typedef enum logic [1:0] {
      FWSFC_IDLE = 2'b00,
      FWSFC_SETUP = 2'b01,
      FWSFC_BURN = 2'b10
   } fwsfc_burn_e;

endpackage

/* fwsfc_sync.sv */
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to sys_clk.
module fwsfc_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Level
   input wire logic d,
   output logic q
);
   logic meta_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

/* fwsfc_ctrl.sv */
// Flash write steering, code protection and security fuse sequencing.
// Assumes the core drives one byte access per cycle and the fuse cells report their blown state.

// Operation
// - PWE set steers pointer stores below 0xFC00 to flash
// - PWE self-clears after each flash byte
// - PWE writes ignored while interrupts enabled
// - Mass erase arm covers one erase start
// - Protect bit resets clear, set only
// - Protect blocks external flash/RAM read-out
// - Key A6 burns fuse, others stop
// - Security bit7 enables fuse programming
// - Security bit5 reads strap pin level
// - Decode SFR and top XDATA ranges
// - Unmapped writes leave state unchanged
// - Protect active only if fuse blown
// - Lockout fuse disables debug permanently
module fwsfc_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Core special-function bus (direct space)
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // Core external data bus
   input wire fwsfc_pkg::fwsfc_acc_s xacc,
   output logic [7:0] xsfr_rdata,
   output logic xsfr_hit,
   output logic xram_sel,
   // Core state
   input wire logic int_enabled,
   // Flash array and erase
   output fwsfc_pkg::fwsfc_flash_s flash_req,
   input wire logic flash_byte_done,
   output logic mass_erase_arm,
   input wire logic mass_erase_start,
   // Fuse cells
   input wire logic code_protect_fuse,
   input wire logic debug_lockout_fuse,
   output logic fuse_burn,
   output logic [1:0] fuse_sel,
   // Pins and debug gating
   input wire logic strap_pin,
   output logic readout_block,
   output logic in_circuit_debug_en
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic pwe_r, meen_r, secure_r, fpe_r;
   logic [1:0] fsel_r;
   logic [7:0] flash_data_r;
   logic [15:0] flash_addr_r;
   logic flash_wr_r;
   logic strap_pin_level;
   fwsfc_pkg::fwsfc_burn_e burn_st_r, burn_st_nxt;

   wire fc_wr = sfr_wr && (sfr_addr == fwsfc_pkg::FLASH_CONTROL_ADDR);
   wire x_top = (xacc.addr >= fwsfc_pkg::XSFR_BASE);
   wire pulse_wr = xacc.wr && (xacc.addr == fwsfc_pkg::FUSE_BURN_PULSE_ADDR);
   wire key_wr = xacc.wr && (xacc.addr == fwsfc_pkg::FUSE_SETUP_KEY_ADDR);
   wire sec_wr = xacc.wr && (xacc.addr == fwsfc_pkg::SECURITY_STATE_ADDR);
   wire sec_rd_hit = (xacc.addr == fwsfc_pkg::SECURITY_STATE_ADDR);
   wire flash_store = xacc.wr && pwe_r && !x_top;
   wire pwe_wr_ok = fc_wr && !int_enabled;
   // Key decodes used by the checks only; read-select decodes shared by the read path and the checks
   wire setup_key_ok = key_wr && (xacc.wdata == fwsfc_pkg::SETUP_KEY);
   wire burn_key_ok = pulse_wr && (xacc.wdata == fwsfc_pkg::BURN_KEY);
   wire burn_allowed = fpe_r && (fsel_r != 2'b00);
   wire fc_rd_sel = sfr_rd && (sfr_addr == fwsfc_pkg::FLASH_CONTROL_ADDR);
   wire sec_rd_sel = xacc.rd && sec_rd_hit;

   fwsfc_sync u_strap_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d(strap_pin),
      .q(strap_pin_level)
   );

   // ----------------------------------------
   // Flash control register
   // ----------------------------------------
   // Completion wins over a new enable, so each byte needs a fresh write
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwe_r <= 1'b0;
      end else if (flash_byte_done) begin
         pwe_r <= 1'b0;
      end else if (pwe_wr_ok) begin
         pwe_r <= sfr_wdata[fwsfc_pkg::PWE_BIT];
      end
   end

   // A register write wins over the erase start, so a fresh arming is never lost
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meen_r <= 1'b0;
      end else if (fc_wr) begin
         meen_r <= sfr_wdata[fwsfc_pkg::MEEN_BIT];
      end else if (mass_erase_start) begin
         meen_r <= 1'b0;
      end
   end

   // Set only: zero writes are dropped, so only chip reset clears it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         secure_r <= 1'b0;
      end else if (fc_wr && sfr_wdata[fwsfc_pkg::SECURE_BIT]) begin
         secure_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Flash store capture
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_wr_r <= 1'b0;
         flash_addr_r <= 16'h0000;
         flash_data_r <= 8'h00;
      end else begin
         flash_wr_r <= flash_store;
         if (flash_store) begin
            flash_addr_r <= xacc.addr;
            flash_data_r <= xacc.wdata;
         end
      end
   end

   // ----------------------------------------
   // Fuse sequencer
   // ----------------------------------------
   always_comb begin
      burn_st_nxt = burn_st_r;
      unique case (burn_st_r)
         fwsfc_pkg::FWSFC_IDLE:
            if (key_wr && xacc.wdata == fwsfc_pkg::SETUP_KEY)
               burn_st_nxt = fwsfc_pkg::FWSFC_SETUP;
         fwsfc_pkg::FWSFC_SETUP:
            if (key_wr && xacc.wdata != fwsfc_pkg::SETUP_KEY)
               burn_st_nxt = fwsfc_pkg::FWSFC_IDLE;
            else if (pulse_wr && xacc.wdata == fwsfc_pkg::BURN_KEY && fpe_r && fsel_r != 2'b00)
               burn_st_nxt = fwsfc_pkg::FWSFC_BURN;
         fwsfc_pkg::FWSFC_BURN:
            if (pulse_wr && xacc.wdata != fwsfc_pkg::BURN_KEY)
               burn_st_nxt = fwsfc_pkg::FWSFC_SETUP;
            else if (key_wr && xacc.wdata != fwsfc_pkg::SETUP_KEY)
               burn_st_nxt = fwsfc_pkg::FWSFC_IDLE;
            else if (!fpe_r)
               burn_st_nxt = fwsfc_pkg::FWSFC_SETUP;
         default:
            burn_st_nxt = fwsfc_pkg::FWSFC_IDLE;
      endcase
   end

   // Fuse select comes from low bits of the security byte (0x81 / 0x82)
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         burn_st_r <= fwsfc_pkg::FWSFC_IDLE;
         fpe_r <= 1'b0;
         fsel_r <= 2'b00;
      end else begin
         burn_st_r <= burn_st_nxt;
         if (sec_wr) begin
            fpe_r <= xacc.wdata[fwsfc_pkg::FPE_BIT];
            fsel_r <= xacc.wdata[fwsfc_pkg::DL_FUSE_BIT:fwsfc_pkg::CP_FUSE_BIT];
         end
      end
   end

   assign fuse_burn = (burn_st_r == fwsfc_pkg::FWSFC_BURN);
   assign fuse_sel = fsel_r;

   // ----------------------------------------
   // Read paths and outputs
   // ----------------------------------------
   wire [7:0] fc_rd = {1'b0, secure_r, 4'h0, meen_r, pwe_r};
   wire [7:0] sec_rd = {2'b00, strap_pin_level, 3'b000, debug_lockout_fuse, code_protect_fuse};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= fwsfc_pkg::REG_RESET;
         xsfr_rdata <= fwsfc_pkg::REG_RESET;
      end else begin
         // Unmapped reads return zero
         sfr_rdata <= fc_rd_sel ? fc_rd : fwsfc_pkg::REG_RESET;
         xsfr_rdata <= sec_rd_sel ? sec_rd : fwsfc_pkg::REG_RESET;
      end
   end

   assign sfr_hit = (sfr_addr == fwsfc_pkg::FLASH_CONTROL_ADDR) && (sfr_wr || sfr_rd);
   assign xsfr_hit = (xacc.wr || xacc.rd) && (pulse_wr || key_wr || sec_rd_hit);
   assign xram_sel = (xacc.wr || xacc.rd) && !x_top && !flash_store;
   assign flash_req = '{wr: flash_wr_r, addr: flash_addr_r, data: flash_data_r};
   assign mass_erase_arm = meen_r;
   assign readout_block = secure_r && code_protect_fuse;
   assign in_circuit_debug_en = !debug_lockout_fuse;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Burn start is judged from an armed setup state, whatever came between key and pulse
   sequence s_setup_armed;
      (burn_st_r == fwsfc_pkg::FWSFC_SETUP) && burn_allowed;
   endsequence

   sequence s_burn_key;
      burn_key_ok;
   endsequence

   a_store_to_flash: assert property (@(posedge sys_clk) disable iff (!rst_b)
      flash_store |=> flash_req.wr && flash_req.data == $past(xacc.wdata)) else $error("store not sent to flash");
   a_pwe_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      flash_byte_done |=> !pwe_r) else $error("enable not cleared after byte");
   a_pwe_int_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fc_wr && int_enabled && !flash_byte_done |=> $stable(pwe_r)) else $error("enable changed with interrupts on");
   a_meen_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
      mass_erase_start && !fc_wr |=> !mass_erase_arm) else $error("erase arm survived cycle");
   a_secure_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
      secure_r |=> secure_r) else $error("protect bit cleared");
   a_readout_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fc_wr && sfr_wdata[fwsfc_pkg::SECURE_BIT] && code_protect_fuse |=> readout_block)
      else $error("protect write did not block read-out");
   a_burn_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fuse_burn && pulse_wr && xacc.wdata != fwsfc_pkg::BURN_KEY |=> !fuse_burn) else $error("burn not stopped");
   a_burn_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_setup_armed ##0 s_burn_key
      |=> fuse_burn) else $error("burn not started");
   a_burn_needs_fpe: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(fuse_burn) |-> $past(fpe_r)) else $error("burn without program enable");
   a_strap_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      xacc.rd && sec_rd_hit |=> xsfr_rdata[fwsfc_pkg::STRAP_BIT] == $past(strap_pin_level))
      else $error("strap bit wrong");
   a_debug_lock: assert property (@(posedge sys_clk) disable iff (!rst_b)
      debug_lockout_fuse |-> !in_circuit_debug_en) else $error("debug not locked");

   // ----------------------------------------
   // Checks of routing, decode and read-back
   // ----------------------------------------
   a_ram_when_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (xacc.wr || xacc.rd) && !pwe_r && !x_top |-> xram_sel)
      else $error("low access not sent to data RAM");
   a_top_not_flash: assert property (@(posedge sys_clk) disable iff (!rst_b)
      xacc.wr && x_top |=> !flash_req.wr)
      else $error("top space store sent to flash");
   a_flash_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
      flash_store |=> flash_req.addr == $past(xacc.addr))
      else $error("flash address wrong");
   a_unmapped_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sfr_wr && !fc_wr && !flash_byte_done && !mass_erase_start |=> $stable({pwe_r, meen_r, secure_r}))
      else $error("unmapped write changed state");
   a_meen_arm: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fc_wr && sfr_wdata[fwsfc_pkg::MEEN_BIT] |=> mass_erase_arm)
      else $error("erase arm not set");
   a_pwe_accept: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pwe_wr_ok && !flash_byte_done |=> pwe_r == $past(sfr_wdata[fwsfc_pkg::PWE_BIT]))
      else $error("enable write not taken");
   a_secure_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fc_wr && !sfr_wdata[fwsfc_pkg::SECURE_BIT] |=> secure_r == $past(secure_r))
      else $error("zero write changed protect bit");

   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !fc_rd_sel |=> sfr_rdata == fwsfc_pkg::REG_RESET)
      else $error("direct read data not idle");
   a_xdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !sec_rd_sel |=> xsfr_rdata == fwsfc_pkg::REG_RESET)
      else $error("external read data not idle");
   a_fpe_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sec_wr |=> fpe_r == $past(xacc.wdata[fwsfc_pkg::FPE_BIT]))
      else $error("program enable not captured");
   a_sel_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sec_wr |=> fuse_sel == $past(xacc.wdata[fwsfc_pkg::DL_FUSE_BIT:fwsfc_pkg::CP_FUSE_BIT]))
      else $error("fuse select not captured");
   a_fuse_state_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sec_rd_sel |=> xsfr_rdata[fwsfc_pkg::DL_FUSE_BIT:fwsfc_pkg::CP_FUSE_BIT] == $past({debug_lockout_fuse, code_protect_fuse}))
      else $error("fuse state read wrong");
   a_setup_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
      burn_st_r == fwsfc_pkg::FWSFC_IDLE && setup_key_ok |=> burn_st_r == fwsfc_pkg::FWSFC_SETUP)
      else $error("setup key not taken");
   a_burn_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fuse_burn && !pulse_wr && !key_wr && fpe_r |=> fuse_burn)
      else $error("burn dropped without a stop");
   a_no_burn_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      burn_st_r == fwsfc_pkg::FWSFC_IDLE |=> !fuse_burn)
      else $error("burn started without setup");

endmodule

/* fwsfc_far_model.sv */
// Flash array and fuse cell model facing the control block.
// Assumes one clock; fuses are permanent and ignore chip reset.
module fwsfc_far_model #(
   parameter int BURN_CYC = 8
) (
   // Clock
   input wire logic sys_clk,
   // Flash array
   input wire fwsfc_pkg::fwsfc_flash_s flash_req,
   input wire logic [3:0] done_dly,
   output logic flash_byte_done,
   // Fuse cells
   input wire logic fuse_burn,
   input wire logic [1:0] fuse_sel,
   input wire logic strap_pin,
   output logic code_protect_fuse,
   output logic debug_lockout_fuse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] wait_r = 5'h00;
   logic [3:0] burn_r = 4'h0;
   logic cp_r = 1'b0;
   logic dl_r = 1'b0;
   logic done_r = 1'b0;
   assign flash_byte_done = done_r;
   assign code_protect_fuse = cp_r;
   assign debug_lockout_fuse = dl_r;
   // Byte write takes a bench-chosen time, so the self-clear is seen fast and slow
   always @(posedge sys_clk) begin
      done_r <= 1'b0;
      if (flash_req.wr) wait_r <= {1'b0, done_dly} + 5'h01;
      else if (wait_r == 5'h01) begin
         done_r <= 1'b1;
         wait_r <= 5'h00;
      end else if (wait_r != 5'h00) wait_r <= wait_r - 5'h01;
      burn_r <= fuse_burn ? burn_r + 4'h1 : 4'h0;
      if (burn_r == BURN_CYC[3:0] && fuse_sel == 2'h1) cp_r <= 1'b1;
      if (burn_r == BURN_CYC[3:0] && fuse_sel == 2'h2 && strap_pin) dl_r <= 1'b1;
   end
endmodule

/* test_flash_write_security_fuse_ctrl.sv */
// Self-checking bench for the flash write and security fuse block.
// Assumes fwsfc_far_model stands in for the flash array and fuse cells.
module test_flash_write_security_fuse_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic sys_clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, int_enabled = 1'b0;
   logic mass_erase_start = 1'b0, strap_pin = 1'b0, rd_q = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
   logic [3:0] done_dly = 4'h0;
   fwsfc_pkg::fwsfc_acc_s xacc = '0;
   fwsfc_pkg::fwsfc_flash_s flash_req;
   logic [7:0] sfr_rdata, xsfr_rdata;
   logic [1:0] fuse_sel;
   logic sfr_hit, xsfr_hit, xram_sel, flash_byte_done, mass_erase_arm, code_protect_fuse;
   logic debug_lockout_fuse, fuse_burn, readout_block, in_circuit_debug_en;
   logic [31:0] exp_q [$];
   logic [31:0] e;
   int n_mismatch = 0, tests_run = 0, seed = 20, cyc = 0;
   fwsfc_ctrl dut (.sys_clk, .rst_b, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit,
      .xacc, .xsfr_rdata, .xsfr_hit, .xram_sel, .int_enabled, .flash_req, .flash_byte_done,
      .mass_erase_arm, .mass_erase_start, .code_protect_fuse, .debug_lockout_fuse, .fuse_burn,
      .fuse_sel, .strap_pin, .readout_block, .in_circuit_debug_en);
   fwsfc_far_model #(.BURN_CYC(8)) far (.sys_clk, .flash_req, .done_dly, .flash_byte_done,
      .fuse_burn, .fuse_sel, .strap_pin, .code_protect_fuse, .debug_lockout_fuse);
   initial forever #20 sys_clk = ~sys_clk;
   // ----------------------------------------
   // Verdict, hang guard and result monitor
   // ----------------------------------------
   task automatic conclude();
      if (exp_q.size() != 0) n_mismatch++;
      $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude();
      end
   end
   // An unexpected flash write finds the queue empty and compares against unknown
   always @(posedge sys_clk) begin
      if (rd_q || flash_req.wr) begin
         e = exp_q.size() ? exp_q.pop_front() : 32'hxxxxxxxx;
         if (flash_req.wr) `CHK({flash_req.addr, flash_req.data}, e[23:0])
         else `CHK((sfr_rdata | xsfr_rdata) & e[31:24], e[7:0])
      end
      rd_q <= sfr_rd | xacc.rd;
   end
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      #1 `CHK(sfr_hit, a == fwsfc_pkg::FLASH_CONTROL_ADDR)
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic xw(input logic [15:0] a, input logic [7:0] d, input logic ram);
      logic hit;
      hit = (a == fwsfc_pkg::FUSE_BURN_PULSE_ADDR) || (a == fwsfc_pkg::FUSE_SETUP_KEY_ADDR);
      hit = hit || (a == fwsfc_pkg::SECURITY_STATE_ADDR);
      @(posedge sys_clk);
      xacc <= '{1'b1, 1'b0, a, d};
      #1 `CHK(xram_sel, ram)
      `CHK(xsfr_hit, hit)
      @(posedge sys_clk);
      xacc.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] d);
      exp_q.push_back({m, 16'h0000, d});
      @(posedge sys_clk);
      if (a[15:8] == 8'h00) begin
         sfr_addr <= a[7:0];
         sfr_rd <= 1'b1;
      end else xacc <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      xacc.rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] a;
      logic [7:0] d;
      logic [7:0] kt [3];
      kt = '{8'h00, 8'h54, 8'h54};
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(16'h00b2, 8'hff, 8'h00);
      rd(16'hffd7, 8'h7f, 8'h00);
      strap_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(16'hffd7, 8'h7f, 8'h20);
      strap_pin <= 1'b0;
      $display("reset values done");
      int_enabled <= 1'b1;
      sw(8'hb2, 8'h01);
      rd(16'h00b2, 8'h01, 8'h00);
      int_enabled <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         a = 16'({$random(seed)} % 32'hfc00);
         d = 8'($random(seed));
         done_dly <= 4'($random(seed));
         sw(8'hb2, 8'h01);
         exp_q.push_back({8'h00, a, d});
         xw(a, d, 1'b0);
         for (int k = 0; k < 40 && flash_byte_done !== 1'b1; k++) @(posedge sys_clk);
         @(posedge sys_clk);
         rd(16'h00b2, 8'h01, 8'h00);
      end
      xw(16'h0123, 8'h5a, 1'b1);
      xw(16'hfbff, 8'h00, 1'b1);
      xw(16'hfc00, 8'h00, 1'b0);
      $display("flash steering done");
      sw(8'hb2, 8'h02);
      #1 `CHK(mass_erase_arm, 1'b1)
      @(posedge sys_clk) mass_erase_start <= 1'b1;
      @(posedge sys_clk) mass_erase_start <= 1'b0;
      #1 `CHK(mass_erase_arm, 1'b0)
      sw(8'hb2, 8'h40);
      sw(8'hb2, 8'h00);
      rd(16'h00b2, 8'h41, 8'h40);
      #1 `CHK(readout_block, 1'b0)
      sw(8'hb7, 8'h03);
      xw(16'hffd4, 8'h00, 1'b0);
      rd(16'h00b3, 8'hff, 8'h00);
      rd(16'h00b2, 8'h43, 8'h40);
      $display("erase, protect and unmapped done");
      for (int f = 0; f < 3; f++) begin
         strap_pin <= (f == 2);
         xw(16'hffd2, kt[f], 1'b0);
         xw(16'hffd7, (f == 2) ? 8'h82 : 8'h81, 1'b0);
         #1 `CHK(fuse_sel, (f == 2) ? 2'h2 : 2'h1)
         xw(16'hffd1, 8'ha6, 1'b0);
         #1 `CHK(fuse_burn, f != 0)
         repeat (12) @(posedge sys_clk);
         xw(16'hffd1, 8'h00, 1'b0);
         #1 `CHK(fuse_burn, 1'b0)
         xw(16'hffd2, 8'h00, 1'b0);
         xw(16'hffd7, 8'h00, 1'b0);
      end
      rd(16'hffd7, 8'h7f, 8'h23);
      #1 `CHK(readout_block, 1'b1)
      `CHK(in_circuit_debug_en, 1'b0)
      $display("fuse burn done");
      @(posedge sys_clk) rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(16'h00b2, 8'h41, 8'h00);
      #1 `CHK(in_circuit_debug_en, 1'b0)
      sw(8'hb2, 8'h40);
      #1 `CHK(readout_block, 1'b1)
      $display("second reset done");
      conclude();
   end
endmodule
